/* hw/vitu_arb_if.sv */
interface vitu_arb_if;
  logic [10:0] req;
  logic gnt_vld;
  logic [3:0] gnt_idx;
  logic [6:0] gnt_vec;
  logic [3:0] gnt_code;
  modport arb (input req, output gnt_vld, output gnt_idx, output gnt_vec, output gnt_code);
  modport ctl (output req, input gnt_vld, input gnt_idx, input gnt_vec, input gnt_code);
endinterface

/* hw/vitu_arbiter.sv */
`include "vitu_consts.svh"
module vitu_arbiter #(
  parameter int NREQ = `VITU_NREQ
) (
  // Request and grant
  vitu_arb_if.arb a
);
  generate
    if (NREQ != `VITU_NREQ)
    begin : g_chk
      $error("vitu_arbiter: request count fixed by vector table");
    end
  endgenerate

  function automatic logic [6:0] vec_of(input logic [3:0] idx);
    case (idx)
      4'h0: vec_of = `VITU_VEC_SWI;
      4'h1: vec_of = `VITU_VEC_EXT0;
      4'h2: vec_of = `VITU_VEC_JTAG;
      4'h3: vec_of = `VITU_VEC_EXT1;
      4'h4: vec_of = `VITU_VEC_TIMER;
      4'h5: vec_of = `VITU_VEC_SRX2;
      4'h6: vec_of = `VITU_VEC_STX2;
      4'h7: vec_of = `VITU_VEC_SRX;
      4'h8: vec_of = `VITU_VEC_STX;
      4'h9: vec_of = `VITU_VEC_PRX;
      default: vec_of = `VITU_VEC_PTX;
    endcase
  endfunction

  function automatic logic [3:0] code_of(input logic [3:0] idx);
    case (idx)
      4'h0: code_of = `VITU_CODE_SWI;
      4'h1: code_of = `VITU_CODE_EXT0;
      4'h2: code_of = `VITU_CODE_JTAG;
      4'h3: code_of = `VITU_CODE_EXT1;
      4'h4: code_of = `VITU_CODE_TIMER;
      4'h5: code_of = `VITU_CODE_SRX2;
      4'h6: code_of = `VITU_CODE_STX2;
      4'h7: code_of = `VITU_CODE_SRX;
      4'h8: code_of = `VITU_CODE_STX;
      4'h9: code_of = `VITU_CODE_PRX;
      default: code_of = `VITU_CODE_PTX;
    endcase
  endfunction

  // Slot order is priority order: the highest set slot wins
  always_comb
  begin
    a.gnt_vld = |a.req;
    a.gnt_idx = 4'h0;
    for (int i = 0; i < NREQ; i++)
    begin
      if (a.req[i])
      begin
        a.gnt_idx = 4'(i);
      end
    end
    a.gnt_vec = vec_of(a.gnt_idx);
    a.gnt_code = code_of(a.gnt_idx);
  end
endmodule

/* hw/vitu_consts.svh */
`ifndef VITU_CONSTS_SVH
`define VITU_CONSTS_SVH
// Sources and arbiter request slots
`define VITU_NSRC 10
`define VITU_NREQ 11
// Register port map
`define VITU_AW 2
`define VITU_DW 16
`define VITU_ADDR_INC 2'h0
`define VITU_ADDR_INS 2'h1
`define VITU_ADDR_STAT 2'h2
`define VITU_EN_RST 10'h000
// Pending bits that software clears by writing one: both pins and the timer
`define VITU_INS_W1C 10'h00D
// Vector addresses
`define VITU_VEC_SWI 7'h02
`define VITU_VEC_EXT0 7'h01
`define VITU_VEC_JTAG 7'h42
`define VITU_VEC_EXT1 7'h04
`define VITU_VEC_TIMER 7'h10
`define VITU_VEC_SRX2 7'h14
`define VITU_VEC_STX2 7'h18
`define VITU_VEC_SRX 7'h2C
`define VITU_VEC_STX 7'h30
`define VITU_VEC_PRX 7'h34
`define VITU_VEC_PTX 7'h38
`define VITU_VEC_UTRAP 7'h46
`define VITU_VEC_DTRAP 7'h03
// Service codes
`define VITU_CODE_NONE 4'h0
`define VITU_CODE_SWI 4'h1
`define VITU_CODE_EXT0 4'h2
`define VITU_CODE_JTAG 4'h8
`define VITU_CODE_EXT1 4'h9
`define VITU_CODE_TIMER 4'hC
`define VITU_CODE_SRX2 4'hD
`define VITU_CODE_STX2 4'hE
`define VITU_CODE_SRX 4'h3
`define VITU_CODE_STX 4'h4
`define VITU_CODE_PRX 4'h5
`define VITU_CODE_PTX 4'h6
`define VITU_CODE_UTRAP 4'h7
`endif

/* hw/vitu_pkg.sv */
package vitu_pkg;
  typedef enum logic [1:0] {m_run, m_isr, m_trap} vitu_mode_t;
  typedef struct packed {
    vitu_mode_t st;
    logic [9:0] en;
    logic [9:0] pend;
    logic swi_p;
    logic utrap_p;
    logic dtrap_p;
    logic trap_usr;
    logic trap_pin_q;
    logic [3:0] srv;
    logic ack;
    logic [3:0] code;
    logic [15:0] ret_ptr;
    logic nores;
    logic fetch;
    logic [15:0] faddr;
    logic [15:0] rdata;
  } vitu_state_t;
endpackage

/* hw/vitu_top.sv */
// Behaviour
// - Ten vectored sources: eight internal, two pins; plus user and debug traps.
// - The software-call instruction raises a software interrupt, kept for debug use.
// - Each interrupt and trap has its own vector and fixed priority.
// - Software interrupt and traps always enabled, no pending bit.
// - Other interrupts have an enable bit and a readable pending bit.
// - Acknowledge pin rises on entering any service routine.
// - A four-bit code names the interrupt or user trap being serviced.
// - Interrupts taken only after an interruptible instruction completes.
// - Simultaneous interrupts are serviced one by one in priority order.
// - Service routines, branches, cache loops, pointer decrements are not interruptible.
// - A trap is taken even during a non-interruptible instruction.
// - A trap inside a cache loop or service routine is not resumable.
// - Traps arriving during a trap routine are ignored.
// - A pending bit of one means the interrupt has occurred.
// - Disabled interrupts never serviced; enabled ones wait for an interruptible point.
// - Taking an interrupt saves the return address in its own register.
// - Enable one unmasks, zero masks; masked events still pend and fire later.
// - Write-one clears both pin and timer bits; interrupt return clears serviced one.
// - User trap vectors to 0x46, highest priority; debug trap to 0x3.
// - Acknowledge held until return; debug traps leave ack and code untouched.
`include "vitu_consts.svh"
module vitu_top #(
  parameter int NSRC = `VITU_NSRC
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // Register port
  input wire logic [`VITU_AW-1:0] i_reg_addr,
  input wire logic [`VITU_DW-1:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [`VITU_DW-1:0] o_reg_rdata,
  // Interrupt sources
  input wire logic [NSRC-1:0] i_irq_evt,
  input wire logic [NSRC-1:0] i_irq_clr,
  // Core sequencer
  input wire logic i_instr_done,
  input wire logic i_instr_nonint,
  input wire logic i_in_cache,
  input wire logic i_icall,
  input wire logic i_ireturn,
  input wire logic [15:0] i_ret_addr,
  // Traps
  input wire logic i_trap_pin,
  input wire logic i_dbg_trap,
  // Program fetch redirect
  output logic o_fetch,
  output logic [15:0] o_fetch_addr,
  output logic [15:0] o_irq_return_ptr,
  // Service status
  output logic o_service_ack_pin,
  output logic [3:0] o_service_code_pins,
  output logic o_in_service,
  output logic o_in_trap,
  output logic o_resumable
);
  generate
    if (NSRC != `VITU_NSRC)
    begin : g_chk
      $error("vitu_top: source count fixed by vector table");
    end
  endgenerate

  vitu_pkg::vitu_state_t q;
  vitu_pkg::vitu_state_t d;
  vitu_arb_if arb_if ();
  logic utrap_evt;
  logic trap_take;
  logic take_user;
  logic irq_take;
  logic [NSRC-1:0] w1c_clr;
  logic [NSRC-1:0] ret_clr;

  vitu_arbiter #(
    .NREQ(`VITU_NREQ)
  ) u_arb (
    .a(arb_if.arb)
  );

  // One-hot pending bit of an arbiter slot; slot zero has none
  function automatic logic [9:0] src_bit(input logic [3:0] idx);
    src_bit = '0;
    if (idx != 4'h0)
    begin
      src_bit[idx - 4'h1] = 1'b1;
    end
  endfunction

  // Only enabled pending bits compete; the software call always does
  assign arb_if.req = {q.pend & q.en, q.swi_p};

  always_comb
  begin
    d = q;
    d.fetch = 1'b0;
    d.rdata = '0;
    d.trap_pin_q = i_trap_pin;
    // Pin level is already synchronous; a held pin gives one trap
    utrap_evt = i_trap_pin && !q.trap_pin_q;
    w1c_clr = '0;
    ret_clr = '0;

    // Traps latch outside a trap routine only
    if (q.st != vitu_pkg::m_trap)
    begin
      if (utrap_evt)
      begin
        d.utrap_p = 1'b1;
      end
      if (i_dbg_trap)
      begin
        d.dtrap_p = 1'b1;
      end
    end
    else
    begin
      d.utrap_p = 1'b0;
      d.dtrap_p = 1'b0;
    end

    // Software call: always enabled, no visible pending bit
    if (i_icall)
    begin
      d.swi_p = 1'b1;
    end

    // Any completed instruction lets a trap in, interruptible or not
    trap_take = i_instr_done && (q.st != vitu_pkg::m_trap) && (q.utrap_p || q.dtrap_p);
    take_user = q.utrap_p;
    irq_take = i_instr_done && !i_instr_nonint && (q.st == vitu_pkg::m_run)
      && arb_if.gnt_vld && !trap_take;

    // Register writes
    if (i_reg_wr && (i_reg_addr == `VITU_ADDR_INC))
    begin
      d.en = i_reg_wdata[NSRC-1:0];
    end
    if (i_reg_wr && (i_reg_addr == `VITU_ADDR_INS))
    begin
      w1c_clr = i_reg_wdata[NSRC-1:0] & `VITU_INS_W1C;
    end

    // Interrupt return
    if (i_ireturn && (q.st == vitu_pkg::m_isr))
    begin
      d.st = vitu_pkg::m_run;
      d.ack = 1'b0;
      d.code = `VITU_CODE_NONE;
      ret_clr = src_bit(q.srv) & `VITU_INS_W1C;
      d.srv = 4'h0;
    end
    if (i_ireturn && (q.st == vitu_pkg::m_trap))
    begin
      d.st = vitu_pkg::m_run;
      d.nores = 1'b0;
      if (q.trap_usr)
      begin
        d.ack = 1'b0;
        d.code = `VITU_CODE_NONE;
      end
    end

    // Pending bits record every occurrence, masked or not; set beats clear
    d.pend = (q.pend & ~(i_irq_clr | w1c_clr | ret_clr)) | i_irq_evt;

    // Vectored entry
    if (irq_take)
    begin
      d.st = vitu_pkg::m_isr;
      d.srv = arb_if.gnt_idx;
      d.ack = 1'b1;
      d.code = arb_if.gnt_code;
      d.ret_ptr = i_ret_addr;
      d.fetch = 1'b1;
      d.faddr = {9'h000, arb_if.gnt_vec};
      if (arb_if.gnt_idx == 4'h0)
      begin
        d.swi_p = 1'b0;
      end
    end

    // Trap entry; user trap outranks debug trap
    if (trap_take)
    begin
      d.st = vitu_pkg::m_trap;
      d.trap_usr = take_user;
      d.utrap_p = 1'b0;
      d.dtrap_p = 1'b0;
      d.fetch = 1'b1;
      // Return pointer is overwritten, so an interrupted routine is lost
      d.ret_ptr = i_ret_addr;
      d.nores = (q.st == vitu_pkg::m_isr) || i_in_cache;
      if (take_user)
      begin
        d.faddr = {9'h000, `VITU_VEC_UTRAP};
        d.ack = 1'b1;
        d.code = `VITU_CODE_UTRAP;
      end
      else
      begin
        // Debug trap keeps pins showing the state it broke into
        d.faddr = {9'h000, `VITU_VEC_DTRAP};
      end
    end

    // Register reads, data in the next cycle only
    if (i_reg_rd)
    begin
      case (i_reg_addr)
        `VITU_ADDR_INC: d.rdata = {6'h00, q.en};
        `VITU_ADDR_INS: d.rdata = {6'h00, q.pend};
        `VITU_ADDR_STAT: d.rdata = {4'h0, q.nores, q.st, q.ack, q.code, q.srv};
        default: d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign o_reg_rdata = q.rdata;
  assign o_fetch = q.fetch;
  assign o_fetch_addr = q.faddr;
  assign o_irq_return_ptr = q.ret_ptr;
  assign o_service_ack_pin = q.ack;
  assign o_service_code_pins = q.code;
  assign o_in_service = (q.st == vitu_pkg::m_isr);
  assign o_in_trap = (q.st == vitu_pkg::m_trap);
  assign o_resumable = !q.nores;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rstn);

  isr_entry_pins_a: assert property (
    irq_take |=> o_service_ack_pin && o_in_service
      && (o_service_code_pins == $past(arb_if.gnt_code)))
    else $error("ack or code wrong after interrupt entry");

  isr_fetch_vec_a: assert property (
    irq_take |=> o_fetch && (o_fetch_addr == {9'h000, $past(arb_if.gnt_vec)})
      && (o_irq_return_ptr == $past(i_ret_addr)))
    else $error("vector fetch or return pointer wrong");

  isr_boundary_a: assert property (
    (o_fetch && o_in_service) |-> $past(i_instr_done) && !$past(i_instr_nonint)
      && !$past(o_in_service))
    else $error("interrupt taken at a non-interruptible point");

  masked_never_a: assert property (
    (o_fetch && o_in_service && (q.srv != 4'h0)) |-> |(src_bit(q.srv) & $past(q.en)))
    else $error("masked interrupt serviced");

  pend_records_a: assert property (
    (i_irq_evt != '0) |=> ((q.pend & $past(i_irq_evt)) == $past(i_irq_evt)))
    else $error("event not recorded in pending bits");

  trap_block_a: assert property (
    (o_in_trap && !i_ireturn) |=> o_in_trap && !o_fetch && !q.utrap_p && !q.dtrap_p)
    else $error("trap accepted inside trap routine");

  user_trap_a: assert property (
    (trap_take && take_user) |=> o_fetch && (o_fetch_addr == {9'h000, `VITU_VEC_UTRAP})
      && o_service_ack_pin && (o_service_code_pins == `VITU_CODE_UTRAP))
    else $error("user trap entry wrong");

  dbg_pins_a: assert property (
    (trap_take && !take_user) |=> $stable(o_service_ack_pin) && $stable(o_service_code_pins)
      && (o_fetch_addr == {9'h000, `VITU_VEC_DTRAP}))
    else $error("debug trap disturbed service pins");

  isr_return_a: assert property (
    (o_in_service && i_ireturn && !(|(i_irq_evt & src_bit(q.srv))))
      |=> !o_service_ack_pin && !o_in_service
      && !(|(q.pend & $past(src_bit(q.srv)) & `VITU_INS_W1C)))
    else $error("interrupt return did not end service");

  trap_lost_a: assert property (
    (trap_take && (o_in_service || i_in_cache)) |=> o_in_trap && !o_resumable)
    else $error("trap from routine or cache left resumable");

  trap_ptr_a: assert property (
    trap_take |=> o_in_trap && (o_irq_return_ptr == $past(i_ret_addr)))
    else $error("trap did not overwrite return pointer");

  swi_entry_a: assert property (
    (irq_take && (arb_if.gnt_idx == 4'h0)) |=> !q.swi_p
      && (o_fetch_addr == {9'h000, `VITU_VEC_SWI}))
    else $error("software call entry wrong");

  prio_order_a: assert property (
    irq_take |-> ((arb_if.req >> arb_if.gnt_idx) == 11'h001))
    else $error("lower priority request granted first");

  isr_ack_high_a: assert property (
    o_in_service |-> o_service_ack_pin && (o_service_code_pins != `VITU_CODE_NONE))
    else $error("ack or code dropped inside routine");

  en_write_a: assert property (
    (i_reg_wr && (i_reg_addr == `VITU_ADDR_INC))
      |=> (q.en == $past(i_reg_wdata[NSRC-1:0])))
    else $error("enable write not applied");

  w1c_clear_a: assert property (
    (i_reg_wr && (i_reg_addr == `VITU_ADDR_INS))
      |=> !(|(q.pend & $past(i_reg_wdata[NSRC-1:0] & ~i_irq_evt) & `VITU_INS_W1C)))
    else $error("write one did not clear pending bit");

  isr_no_nest_a: assert property (
    (o_in_service && !trap_take) |=> !o_fetch)
    else $error("interrupt taken inside a routine");

  nonint_hold_a: assert property (
    (i_instr_done && i_instr_nonint && !trap_take) |=> !o_fetch)
    else $error("interrupt taken after non-interruptible instruction");

  trap_nonint_a: assert property (
    (i_instr_done && i_instr_nonint && !o_in_trap && (q.utrap_p || q.dtrap_p))
      |=> o_fetch && o_in_trap)
    else $error("trap held off by non-interruptible instruction");

  pend_hold_a: assert property (
    ((i_irq_clr == '0) && !i_reg_wr && !i_ireturn)
      |=> ((q.pend & $past(q.pend)) == $past(q.pend)))
    else $error("pending bit lost without a clear");

  swi_latch_a: assert property (
    (i_icall && !irq_take) |=> q.swi_p)
    else $error("software call not latched");

  dbg_latch_a: assert property (
    (i_dbg_trap && !o_in_trap && !trap_take) |=> q.dtrap_p)
    else $error("debug trap not latched");
endmodule

/* tb/test_vectored_interrupt_trap_unit.sv */
`include "vitu_consts.svh"
module test_vectored_interrupt_trap_unit;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic [9:0] evt;
  logic [9:0] clr = 10'h000;
  logic done = 1'b0;
  logic nonint_q = 1'b0;
  logic in_cache = 1'b0;
  logic icall = 1'b0;
  logic iret = 1'b0;
  logic [15:0] ret_addr = 16'h0000;
  logic trap_pin;
  logic dbg;
  logic fetch;
  logic [15:0] faddr;
  logic [15:0] rptr;
  logic ack;
  logic [3:0] code;
  logic in_srv;
  logic in_trap;
  logic resum;
  int mismatches = 0;
  int check_count = 0;

  vitu_top vitu_top_i (
    .i_clk_sys(clk),
    .i_rstn(rstn),
    .i_reg_addr(addr),
    .i_reg_wdata(wdata),
    .i_reg_wr(wr),
    .i_reg_rd(rd),
    .o_reg_rdata(rdata),
    .i_irq_evt(evt),
    .i_irq_clr(clr),
    .i_instr_done(done),
    .i_instr_nonint(nonint_q),
    .i_in_cache(in_cache),
    .i_icall(icall),
    .i_ireturn(iret),
    .i_ret_addr(ret_addr),
    .i_trap_pin(trap_pin),
    .i_dbg_trap(dbg),
    .o_fetch(fetch),
    .o_fetch_addr(faddr),
    .o_irq_return_ptr(rptr),
    .o_service_ack_pin(ack),
    .o_service_code_pins(code),
    .o_in_service(in_srv),
    .o_in_trap(in_trap),
    .o_resumable(resum)
  );
  vitu_src_model vitu_src_model_i (
    .i_clk_sys(clk),
    .o_irq_evt(evt),
    .o_trap_pin(trap_pin),
    .o_dbg_trap(dbg)
  );

  initial
  begin
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp, input string what);
    chk({15'h0000, got}, {15'h0000, exp}, what);
  endtask
  task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_chk(input logic [1:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp, "register read");
  endtask
  task automatic pulse_clr(input logic [9:0] m);
    @(posedge clk);
    clr <= m;
    @(posedge clk);
    clr <= 10'h000;
  endtask
  // Fetch pulse stands one cycle only, so it is judged in that cycle
  task automatic step(input logic ni, input logic exp_f, input logic [6:0] vec,
    input logic [3:0] exp_code);
    logic [15:0] ra;
    ra = 16'hA000 + 16'(check_count);
    @(posedge clk);
    done <= 1'b1;
    nonint_q <= ni;
    ret_addr <= ra;
    @(posedge clk);
    done <= 1'b0;
    @(negedge clk);
    chk1(fetch, exp_f, "fetch pulse");
    chk({12'h000, code}, {12'h000, exp_code}, "service code");
    if (exp_f)
    begin
      chk(faddr, {9'h000, vec}, "vector");
      chk(rptr, ra, "return pointer");
    end
  endtask
  task automatic do_return();
    @(posedge clk);
    iret <= 1'b1;
    @(posedge clk);
    iret <= 1'b0;
    @(negedge clk);
  endtask

  task automatic t_reset();
    reg_chk(`VITU_ADDR_INC, 16'h0000);
    reg_chk(`VITU_ADDR_INS, 16'h0000);
    reg_chk(`VITU_ADDR_STAT, 16'h0000);
    chk1(ack, 1'b0, "ack idle");
    chk1(resum, 1'b1, "resumable idle");
  endtask
  task automatic t_masked_poll();
    vitu_src_model_i.fire(10'h008);
    reg_chk(`VITU_ADDR_INS, 16'h0008);
    step(1'b0, 1'b0, 7'h00, `VITU_CODE_NONE);
    reg_wr(`VITU_ADDR_INC, 16'h0008);
    step(1'b0, 1'b1, `VITU_VEC_TIMER, `VITU_CODE_TIMER);
    chk1(ack, 1'b1, "ack in routine");
    chk1(in_srv, 1'b1, "in service");
    do_return();
    chk1(ack, 1'b0, "ack after return");
    reg_chk(`VITU_ADDR_INS, 16'h0000);
  endtask
  task automatic t_dbg();
    vitu_src_model_i.dbg_trap();
    in_cache <= 1'b1;
    step(1'b1, 1'b1, `VITU_VEC_DTRAP, `VITU_CODE_NONE);
    chk1(ack, 1'b0, "ack on debug trap");
    chk1(resum, 1'b0, "cache loop trap resumable");
    // Trap mode, not resumable, ack and code still idle
    reg_chk(`VITU_ADDR_STAT, 16'h0C00);
    @(posedge clk);
    in_cache <= 1'b0;
    do_return();
    chk1(resum, 1'b1, "resumable after return");
  endtask
  task automatic t_swi();
    @(posedge clk);
    icall <= 1'b1;
    @(posedge clk);
    icall <= 1'b0;
    step(1'b0, 1'b1, `VITU_VEC_SWI, `VITU_CODE_SWI);
    reg_chk(`VITU_ADDR_INS, 16'h0000);
    do_return();
  endtask
  task automatic t_prio_trap();
    reg_wr(`VITU_ADDR_INC, 16'h03FF);
    vitu_src_model_i.fire(10'h201);
    step(1'b1, 1'b0, 7'h00, `VITU_CODE_NONE);
    step(1'b0, 1'b1, `VITU_VEC_PTX, `VITU_CODE_PTX);
    step(1'b0, 1'b0, 7'h00, `VITU_CODE_PTX);
    pulse_clr(10'h200);
    do_return();
    step(1'b0, 1'b1, `VITU_VEC_EXT0, `VITU_CODE_EXT0);
    vitu_src_model_i.user_trap();
    step(1'b1, 1'b1, `VITU_VEC_UTRAP, `VITU_CODE_UTRAP);
    chk1(in_trap, 1'b1, "in trap");
    chk1(resum, 1'b0, "not resumable");
    vitu_src_model_i.dbg_trap();
    step(1'b0, 1'b0, 7'h00, `VITU_CODE_UTRAP);
    do_return();
    chk1(in_trap, 1'b0, "trap left");
    reg_wr(`VITU_ADDR_INC, 16'h0000);
    reg_wr(`VITU_ADDR_INS, 16'h0001);
  endtask
  task automatic t_w1c();
    vitu_src_model_i.fire(10'h3FF);
    reg_chk(`VITU_ADDR_INS, 16'h03FF);
    reg_wr(`VITU_ADDR_INS, 16'h03FF);
    reg_chk(`VITU_ADDR_INS, 16'h03F2);
    reg_wr(2'h3, 16'hFFFF);
    reg_chk(2'h3, 16'h0000);
    reg_chk(`VITU_ADDR_INC, 16'h0000);
  endtask
  // Mid-run reset must drop pending bits left by the previous scenario
  task automatic t_rerun();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
  endtask

  task automatic wrap_up();
    $display("Checks: %0d, mismatches: %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_masked_poll();
    t_dbg();
    t_swi();
    t_prio_trap();
    t_w1c();
    t_rerun();
    wrap_up();
  end
  // Whole sequence needs about a hundred cycles
  initial
  begin
    repeat (3000) @(posedge clk);
    mismatches++;
    wrap_up();
  end
endmodule

/* tb/vitu_src_model.sv */
module vitu_src_model (
  // Clock
  input wire logic i_clk_sys,
  // Events towards the unit
  output logic [9:0] o_irq_evt,
  output logic o_trap_pin,
  output logic o_dbg_trap
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    o_irq_evt = 10'h000;
    o_trap_pin = 1'b0;
    o_dbg_trap = 1'b0;
  end
  // One pulse per occurrence, several sources may fire together
  task automatic fire(input logic [9:0] m);
    @(posedge i_clk_sys);
    o_irq_evt <= m;
    @(posedge i_clk_sys);
    o_irq_evt <= 10'h000;
  endtask
  // Pin held long enough for the rise to be seen, then released low
  task automatic user_trap();
    @(posedge i_clk_sys);
    o_trap_pin <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    o_trap_pin <= 1'b0;
  endtask
  task automatic dbg_trap();
    @(posedge i_clk_sys);
    o_dbg_trap <= 1'b1;
    @(posedge i_clk_sys);
    o_dbg_trap <= 1'b0;
  endtask
endmodule
